//--- include/rcd_core_map.vh
// Constants shared by the RISC core datapath: opcodes, fields, addresses.
`ifndef RCD_CORE_MAP_VH
`define RCD_CORE_MAP_VH

// Instruction word width and opcode field position.
`define RCD_IW 12
`define RCD_OP_HI 11
`define RCD_OP_LO 8
// Destination select bit of file instructions: 1 = file, 0 = accumulator.
`define RCD_DEST_BIT 5
// File address field of file instructions.
`define RCD_FADDR_HI 4
// Literal or jump target field.
`define RCD_LIT_HI 7

// Opcodes in bits 11..8 of the instruction word.
`define RCD_OP_NOP 4'h0
`define RCD_OP_ADDWF 4'h1
`define RCD_OP_SUBWF 4'h2
`define RCD_OP_ANDWF 4'h3
`define RCD_OP_IORWF 4'h4
`define RCD_OP_XORWF 4'h5
`define RCD_OP_RLF 4'h6
`define RCD_OP_RRF 4'h7
`define RCD_OP_COMF 4'h8
`define RCD_OP_MOVF 4'h9
`define RCD_OP_MOVWF 4'hA
`define RCD_OP_MOVLW 4'hB
`define RCD_OP_ANDLW 4'hC
`define RCD_OP_IORLW 4'hD
`define RCD_OP_GOTO 4'hE
`define RCD_OP_COMW 4'hF

// The word loaded into the execute stage when a fetch is discarded.
`define RCD_NOP_WORD 12'h000

// Data memory locations of the special function registers.
`define RCD_ADDR_INDF 5'h00
`define RCD_ADDR_PCL 5'h02
`define RCD_ADDR_STATUS 5'h03
`define RCD_ADDR_FSR 5'h04

// Flag positions inside the status register.
`define RCD_ST_C 0
`define RCD_ST_DC 1
`define RCD_ST_Z 2

// Reset values.
`define RCD_W_RESET 8'h00
`define RCD_FSR_RESET 8'h00
`define RCD_FLAGS_RESET 3'h0

// Clocks per instruction cycle; the clock output runs at this fraction.
`define RCD_CLKS_PER_CYCLE 4

`endif

//--- src/rcd_alu.v
// Eight-bit arithmetic and logic unit with flag generation.
`default_nettype none
`include "rcd_core_map.vh"

module rcd_alu
(
    input wire [3:0] op,
    input wire [7:0] acc,
    input wire [7:0] opnd,
    input wire carry_in,
    output reg [7:0] result,
    output reg carry_out,
    output reg digit_carry_out,
    output reg upd_c,
    output reg upd_dc,
    output reg upd_z,
    output wire zero_out
);

    // Nine-bit sum and five-bit low nibble sum, so carries are visible.
    reg [8:0] sum9;
    reg [4:0] nib5;

    // Operation decode; each branch also states which flags it touches.
    always @*
    begin
        sum9 = 9'h000;
        nib5 = 5'h00;
        result = opnd;
        carry_out = carry_in;
        digit_carry_out = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        case (op)
            `RCD_OP_ADDWF:
            begin
                sum9 = {1'b0, opnd} + {1'b0, acc};
                nib5 = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
                result = sum9[7:0];
                carry_out = sum9[8];
                digit_carry_out = nib5[4];
                upd_c = 1'b1;
                upd_dc = 1'b1;
                upd_z = 1'b1;
            end
            `RCD_OP_SUBWF:
            begin
                // File minus accumulator as opnd + ~acc + 1, so the
                // carries come out as inverted borrows.
                sum9 = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
                nib5 = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                result = sum9[7:0];
                carry_out = sum9[8];
                digit_carry_out = nib5[4];
                upd_c = 1'b1;
                upd_dc = 1'b1;
                upd_z = 1'b1;
            end
            `RCD_OP_ANDWF, `RCD_OP_ANDLW:
            begin
                result = opnd & acc;
                upd_z = 1'b1;
            end
            `RCD_OP_IORWF, `RCD_OP_IORLW:
            begin
                result = opnd | acc;
                upd_z = 1'b1;
            end
            `RCD_OP_XORWF:
            begin
                result = opnd ^ acc;
                upd_z = 1'b1;
            end
            `RCD_OP_RLF:
            begin
                // Rotate left through carry.
                result = {opnd[6:0], carry_in};
                carry_out = opnd[7];
                upd_c = 1'b1;
            end
            `RCD_OP_RRF:
            begin
                // Rotate right through carry.
                result = {carry_in, opnd[7:1]};
                carry_out = opnd[0];
                upd_c = 1'b1;
            end
            `RCD_OP_COMF:
            begin
                result = ~opnd;
                upd_z = 1'b1;
            end
            `RCD_OP_MOVF:
            begin
                result = opnd;
                upd_z = 1'b1;
            end
            `RCD_OP_MOVWF:
            begin
                result = acc;
            end
            `RCD_OP_COMW:
            begin
                // Single-operand form working on the accumulator.
                result = ~acc;
                upd_z = 1'b1;
            end
            default:
            begin
                result = opnd;
            end
        endcase
    end

    // Zero detect over the full eight-bit result.
    assign zero_out = (result == 8'h00);

endmodule

`default_nettype wire

//--- src/rcd_file_ram.v
// General purpose file register memory with a registered read port.
`default_nettype none

module rcd_file_ram
#(
    parameter DW = 8,
    parameter AW = 5
)
(
    input wire clk,
    input wire rst_b,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);

    // Storage; contents are undefined after power-up, as in real SRAM.
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write port.
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port; data appear one clock after the enabled address.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data <= {DW{1'b0}};
        end
        else if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

//--- src/rcd_core.v
// RISC core datapath: two-stage fetch/execute pipeline with file registers.
`default_nettype none
`include "rcd_core_map.vh"

module rcd_core
#(
    parameter PROG_DEPTH = 2048,
    parameter PCW = 11,
    parameter RESET_VECTOR = 0
)
(
    input wire clk,
    input wire rst_b,
    input wire master_clear_input_b,
    input wire rc_mode_select,
    input wire [`RCD_IW-1:0] prog_data,
    output reg [PCW-1:0] prog_addr_q,
    output reg quarter_rate_clock_output_q,
    output reg [7:0] working_acc_q,
    output reg [2:0] status_flags_q
);

    // Instruction cycle phases; one phase per clock, four per cycle.
    localparam PH_Q1 = 2'h0;
    localparam PH_Q2 = 2'h1;
    localparam PH_Q3 = 2'h2;
    localparam PH_Q4 = 2'h3;

    // Pin synchronisers for master clear and the oscillator mode strap.
    reg master_clear_input_s1_q;
    reg master_clear_input_s2_q;
    reg rc_s1_q;
    reg rc_s2_q;
    // Current phase within the instruction cycle.
    reg [1:0] phase_q;
    // Execute stage: the instruction now being carried out.
    reg [`RCD_IW-1:0] ir_q;
    // Indirect address pointer.
    reg [7:0] fsr_q;
    // File operand captured at the end of the second phase.
    reg [7:0] operand_q;
    // Combinational operand and next-state values.
    reg [7:0] file_rd_val;
    reg [2:0] status_flags_d;

    wire core_run;
    wire [3:0] op;
    wire [4:0] faddr;
    wire [4:0] eff_addr;
    wire is_file_op;
    wire is_lit_op;
    wire dest_file;
    wire file_write;
    wire acc_write;
    wire is_special;
    wire pcl_write;
    wire flow_change;
    wire cycle_end;
    wire [PCW-1:0] pc_inc;
    wire [PCW-1:0] branch_target;
    wire [7:0] alu_opnd;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_dc;
    wire alu_z;
    wire upd_c;
    wire upd_dc;
    wire upd_z;
    wire [7:0] ram_rd_data;

    // Core runs only while master clear has been high for two clocks.
    assign core_run = master_clear_input_s2_q;

    // Instruction fields.
    assign op = ir_q[`RCD_OP_HI:`RCD_OP_LO];
    assign faddr = ir_q[`RCD_FADDR_HI:0];

    // File instructions span ADDWF through MOVWF.
    assign is_file_op = (op >= `RCD_OP_ADDWF) && (op <= `RCD_OP_MOVWF);
    // Literal instructions take their operand from the instruction word.
    assign is_lit_op = (op == `RCD_OP_MOVLW) || (op == `RCD_OP_ANDLW) ||
                       (op == `RCD_OP_IORLW);

    // Address zero is the indirect port: the pointer supplies the address.
    assign eff_addr = (faddr == `RCD_ADDR_INDF) ? fsr_q[4:0] : faddr;

    // Locations 0 to 4 are special function registers, not RAM.
    assign is_special = (eff_addr <= `RCD_ADDR_FSR);

    // Result goes to the file when the destination bit says so, or always
    // for the store-accumulator instruction.
    assign dest_file = (op == `RCD_OP_MOVWF) ||
                       (is_file_op && ir_q[`RCD_DEST_BIT]);
    assign file_write = is_file_op && dest_file;
    // The accumulator is written only by instructions, never by address.
    assign acc_write = (is_file_op && !dest_file) || is_lit_op ||
                       (op == `RCD_OP_COMW);

    // Writing the program counter low byte is a change of program flow.
    assign pcl_write = file_write && (eff_addr == `RCD_ADDR_PCL);
    assign flow_change = (op == `RCD_OP_GOTO) || pcl_write;

    // All architectural updates land on the edge that closes phase four.
    assign cycle_end = core_run && (phase_q == PH_Q4);

    // Sequential fetch address wraps at the top of program space.
    assign pc_inc = (prog_addr_q == PROG_DEPTH - 1) ? {PCW{1'b0}} :
                    prog_addr_q + {{(PCW-1){1'b0}}, 1'b1};

    // Jumps and PC-low writes keep the upper program counter bits.
    assign branch_target = {prog_addr_q[PCW-1:8],
        (op == `RCD_OP_GOTO) ? ir_q[`RCD_LIT_HI:0] : alu_res};

    // Second operand: literal from the word, or the captured file value.
    assign alu_opnd = is_lit_op ? ir_q[`RCD_LIT_HI:0] : operand_q;

    // Arithmetic unit; the accumulator is always the first source.
    rcd_alu u_alu
    (
        .op(op),
        .acc(working_acc_q),
        .opnd(alu_opnd),
        .carry_in(status_flags_q[`RCD_ST_C]),
        .result(alu_res),
        .carry_out(alu_c),
        .digit_carry_out(alu_dc),
        .upd_c(upd_c),
        .upd_dc(upd_dc),
        .upd_z(upd_z),
        .zero_out(alu_z)
    );

    // General purpose registers on the data bus, apart from program fetch.
    rcd_file_ram #(.DW(8), .AW(5)) u_ram
    (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(cycle_end && file_write && !is_special),
        .wr_addr(eff_addr),
        .wr_data(alu_res),
        .rd_en(phase_q == PH_Q1),
        .rd_addr(eff_addr),
        .rd_data(ram_rd_data)
    );

    // Data memory read mux: special registers sit beside the RAM.
    always @*
    begin
        file_rd_val = ram_rd_data;
        case (eff_addr)
            `RCD_ADDR_INDF:
            begin
                // Pointer aimed at the indirect port reads as zero.
                file_rd_val = 8'h00;
            end
            `RCD_ADDR_PCL:
            begin
                // Reads the fetch address, i.e. the next instruction.
                file_rd_val = prog_addr_q[7:0];
            end
            `RCD_ADDR_STATUS:
            begin
                file_rd_val = {5'h00, status_flags_q};
            end
            `RCD_ADDR_FSR:
            begin
                file_rd_val = fsr_q;
            end
            default:
            begin
                file_rd_val = ram_rd_data;
            end
        endcase
    end

    // Next flags: a direct status write first, then ALU updates on top,
    // so the instruction's own flag result is never lost.
    always @*
    begin
        status_flags_d = status_flags_q;
        if (file_write && (eff_addr == `RCD_ADDR_STATUS))
        begin
            status_flags_d = alu_res[2:0];
        end
        if (upd_c)
        begin
            status_flags_d[`RCD_ST_C] = alu_c;
        end
        if (upd_dc)
        begin
            status_flags_d[`RCD_ST_DC] = alu_dc;
        end
        if (upd_z)
        begin
            status_flags_d[`RCD_ST_Z] = alu_z;
        end
    end

    // Two-flop synchronisers; reset holds master clear asserted.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            master_clear_input_s1_q <= 1'b0;
            master_clear_input_s2_q <= 1'b0;
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
        end
        else
        begin
            master_clear_input_s1_q <= master_clear_input_b;
            master_clear_input_s2_q <= master_clear_input_s1_q;
            rc_s1_q <= rc_mode_select;
            rc_s2_q <= rc_s1_q;
        end
    end

    // Phase counter and quarter-rate clock output. The output is high in
    // phases three and four, registered so it never glitches.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_q <= PH_Q1;
            quarter_rate_clock_output_q <= 1'b0;
        end
        else if (!core_run)
        begin
            // Held in reset: restart at phase one, clock output low.
            phase_q <= PH_Q1;
            quarter_rate_clock_output_q <= 1'b0;
        end
        else
        begin
            case (phase_q)
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: phase_q <= PH_Q1;
                default: phase_q <= PH_Q1;
            endcase
            // Only in RC mode; otherwise the pin belongs to the crystal.
            quarter_rate_clock_output_q <= rc_s2_q &&
                ((phase_q == PH_Q2) || (phase_q == PH_Q3));
        end
    end

    // Operand capture: RAM data read in phase one are ready at phase two.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            operand_q <= 8'h00;
        end
        else if (phase_q == PH_Q2)
        begin
            operand_q <= file_rd_val;
        end
    end

    // Fetch stage and execute stage register. Each instruction cycle the
    // word at the fetch address is taken while the previous word executes.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prog_addr_q <= RESET_VECTOR[PCW-1:0];
            ir_q <= `RCD_NOP_WORD;
        end
        else if (!core_run)
        begin
            prog_addr_q <= RESET_VECTOR[PCW-1:0];
            ir_q <= `RCD_NOP_WORD;
        end
        else if (cycle_end)
        begin
            if (flow_change)
            begin
                // Discard the prefetched word; the next cycle executes a
                // bubble while the target is fetched.
                prog_addr_q <= branch_target;
                ir_q <= `RCD_NOP_WORD;
            end
            else
            begin
                prog_addr_q <= pc_inc;
                ir_q <= prog_data;
            end
        end
    end

    // Accumulator, pointer and flags update at the end of the cycle.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            working_acc_q <= `RCD_W_RESET;
            fsr_q <= `RCD_FSR_RESET;
            status_flags_q <= `RCD_FLAGS_RESET;
        end
        else if (!core_run)
        begin
            working_acc_q <= `RCD_W_RESET;
            fsr_q <= `RCD_FSR_RESET;
            status_flags_q <= `RCD_FLAGS_RESET;
        end
        else if (cycle_end)
        begin
            if (acc_write)
            begin
                working_acc_q <= alu_res;
            end
            if (file_write && (eff_addr == `RCD_ADDR_FSR))
            begin
                fsr_q <= alu_res;
            end
            status_flags_q <= status_flags_d;
        end
    end

endmodule

`default_nettype wire

//--- verification/rcd_prog_mem.sv
// Program memory model that answers the core's instruction fetches.
`default_nettype none
`include "rcd_core_map.vh"

module rcd_prog_mem
#(
    parameter DEPTH = 512,
    parameter PCW = 9
)
(
    input wire logic [PCW-1:0] addr,
    output logic [`RCD_IW-1:0] data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Whole words only; the bench fills it just before each master clear pulse.
    logic [`RCD_IW-1:0] rom [0:DEPTH-1];

    // Unwritten words read as no-operation so a stray fetch stays harmless.
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            rom[i] = `RCD_NOP_WORD;
        end
    end

    // Own bus beside the data path, answering within the same clock.
    assign data = rom[addr];
endmodule
`default_nettype wire

//--- verification/rcd_core_checker.sv
// Port assertions for the RISC core datapath.
`default_nettype none
`include "rcd_core_map.vh"

module rcd_core_checker
#(
    parameter PROG_DEPTH = 2048,
    parameter PCW = 11,
    parameter RESET_VECTOR = 0
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic master_clear_input_b,
    input wire logic rc_mode_select,
    input wire logic [`RCD_IW-1:0] prog_data,
    input wire logic [PCW-1:0] prog_addr_q,
    input wire logic quarter_rate_clock_output_q,
    input wire logic [7:0] working_acc_q,
    input wire logic [2:0] status_flags_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // Recent samples of the pins, which reach the core through synchronisers.
    logic [3:0] mc_hist_q;
    logic [7:0] rc_hist_q;

    // Shift the pin samples so settling after a change can be judged.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mc_hist_q <= 4'h0;
            rc_hist_q <= 8'h00;
        end
        else
        begin
            mc_hist_q <= {mc_hist_q[2:0], master_clear_input_b};
            rc_hist_q <= {rc_hist_q[6:0], rc_mode_select};
        end
    end

    // Checks pause while a pin change is still crossing the synchronisers.
    wire unsettled = !rst_b || !master_clear_input_b || mc_hist_q != 4'hF
        || rc_hist_q != {8{rc_mode_select}};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (unsettled);

    sequence s_clk_high;
        quarter_rate_clock_output_q [*2];
    endsequence
    sequence s_clk_low;
        !quarter_rate_clock_output_q [*2];
    endsequence

    property p_addr_hold;
        $changed(prog_addr_q) |=> $stable(prog_addr_q) [*3];
    endproperty
    property p_acc_at_fetch;
        $changed(working_acc_q) |-> $changed(prog_addr_q);
    endproperty
    property p_flag_at_fetch;
        $changed(status_flags_q) |-> $changed(prog_addr_q);
    endproperty
    property p_qclk_shape;
        $rose(quarter_rate_clock_output_q) |-> s_clk_high ##1 s_clk_low;
    endproperty
    property p_qclk_off;
        !rc_mode_select |-> !quarter_rate_clock_output_q;
    endproperty
    property p_qclk_phase;
        $fell(quarter_rate_clock_output_q) |-> $changed(prog_addr_q);
    endproperty
    property p_reset;
        disable iff (!rst_b)
        (mc_hist_q == 4'h0 && !master_clear_input_b) |->
            (prog_addr_q == RESET_VECTOR && !quarter_rate_clock_output_q
            && working_acc_q == 8'h00 && status_flags_q == 3'h0);
    endproperty
    property p_zero;
        $changed(working_acc_q) && $changed(status_flags_q[`RCD_ST_Z]) |->
            status_flags_q[`RCD_ST_Z] == (working_acc_q == 8'h00);
    endproperty
    property p_addr_range;
        prog_addr_q < PROG_DEPTH;
    endproperty

    a_addr_hold: assert property (p_addr_hold)
        else $error("fetch address did not stand four clocks");
    a_acc_at_fetch: assert property (p_acc_at_fetch)
        else $error("accumulator changed off the fetch edge");
    a_flag_at_fetch: assert property (p_flag_at_fetch)
        else $error("flags changed off the fetch edge");
    a_qclk_shape: assert property (p_qclk_shape)
        else $error("clock output not two high then two low");
    a_qclk_off: assert property (p_qclk_off)
        else $error("clock output active outside RC mode");
    a_qclk_phase: assert property (p_qclk_phase)
        else $error("clock output fell away from the fetch edge");
    a_reset: assert property (p_reset)
        else $error("master clear did not hold reset values");
    a_zero: assert property (p_zero)
        else $error("zero flag disagrees with accumulator");
    a_addr_range: assert property (p_addr_range)
        else $error("fetch address beyond program space");
endmodule

bind rcd_core rcd_core_checker #(.PROG_DEPTH(PROG_DEPTH), .PCW(PCW),
    .RESET_VECTOR(RESET_VECTOR)) u_chk (.clk(clk), .rst_b(rst_b),
    .master_clear_input_b(master_clear_input_b),
    .rc_mode_select(rc_mode_select), .prog_data(prog_data),
    .prog_addr_q(prog_addr_q),
    .quarter_rate_clock_output_q(quarter_rate_clock_output_q),
    .working_acc_q(working_acc_q), .status_flags_q(status_flags_q));
`default_nettype wire

//--- verification/rcd_core_tb.sv
// Self-checking bench for the RISC core datapath, small program space.
`default_nettype none
`include "rcd_core_map.vh"

`define RCD_CHK(what, exp, got) \
    begin \
        num_checks = num_checks + 1; \
        if ((got) !== (exp)) \
        begin \
            errors = errors + 1; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module rcd_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic mc_b = 1'b1; // Master clear pin, idle high.
    logic rc_sel = 1'b1; // RC oscillator strap.
    logic seen_stray = 1'b0; // Set if a dropped fetch ever executed.
    wire [`RCD_IW-1:0] prog_data;
    wire [8:0] addr;
    wire qclk;
    wire [7:0] acc;
    wire [2:0] flags;
    int errors = 0;
    int num_checks = 0;

    rcd_core #(.PROG_DEPTH(512), .PCW(9), .RESET_VECTOR(0)) dut (
        .clk(clk), .rst_b(rst_b), .master_clear_input_b(mc_b),
        .rc_mode_select(rc_sel), .prog_data(prog_data),
        .prog_addr_q(addr), .quarter_rate_clock_output_q(qclk),
        .working_acc_q(acc), .status_flags_q(flags));

    rcd_prog_mem #(.DEPTH(512), .PCW(9)) mem (.addr(addr), .data(prog_data));

    // A 40 ns clock.
    always #20 clk = ~clk;

    // The flow program marks 0x55 as a word that must never execute.
    always @(posedge clk)
    begin
        if (acc === 8'h55)
        begin
            seen_stray <= 1'b1;
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Empty the low program area and the stray marker.
    task automatic clear_prog;
        for (int i = 0; i < 64; i++)
        begin
            mem.rom[i] = `RCD_NOP_WORD;
        end
        seen_stray = 1'b0;
    endtask

    // Pulse master clear long enough to see the reset values at the ports.
    task automatic restart;
        @(posedge clk);
        mc_b <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        `RCD_CHK("reset address", 9'h000, addr)
        `RCD_CHK("reset acc", 8'h00, acc)
        `RCD_CHK("reset flags", 3'h0, flags)
        @(posedge clk);
        mc_b <= 1'b1;
    endtask

    // Wait for a fetch address, bounded; optionally check the clocks taken.
    task automatic reach(input logic [8:0] a, input int exp);
        int n;
        n = 0;
        while (addr !== a && n < 200)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        `RCD_CHK("fetch address", a, addr)
        if (exp > 0)
        begin
            `RCD_CHK("clocks to address", exp, n)
        end
    endtask

    // Put f in file 5 and w in the accumulator, then run one operation.
    task automatic run_op(input logic [3:0] op, input logic [7:0] f,
        input logic [7:0] w, input logic [7:0] ew, input logic [2:0] ef);
        clear_prog();
        mem.rom[0] = {`RCD_OP_MOVLW, f};
        mem.rom[1] = 12'hA25;
        mem.rom[2] = {`RCD_OP_MOVLW, w};
        mem.rom[3] = {op, 8'h05};
        restart();
        reach(9'h005, 0);
        `RCD_CHK("alu result", ew, acc)
        `RCD_CHK("alu flags", ef, flags)
    endtask

    // Sums and differences at the nibble and byte boundaries.
    task automatic t_arith;
        run_op(`RCD_OP_ADDWF, 8'h0F, 8'h01, 8'h10, 3'h2);
        run_op(`RCD_OP_ADDWF, 8'h0F, 8'hF1, 8'h00, 3'h7);
        run_op(`RCD_OP_ADDWF, 8'h80, 8'h80, 8'h00, 3'h5);
        run_op(`RCD_OP_SUBWF, 8'h0F, 8'h10, 8'hFF, 3'h2);
        run_op(`RCD_OP_SUBWF, 8'h10, 8'h01, 8'h0F, 3'h1);
        run_op(`RCD_OP_SUBWF, 8'h05, 8'h05, 8'h00, 3'h7);
    endtask

    // Logic, rotate, complement and literal forms on both operand kinds.
    task automatic t_logic;
        run_op(`RCD_OP_ANDWF, 8'hF0, 8'h3C, 8'h30, 3'h0);
        run_op(`RCD_OP_IORWF, 8'h00, 8'h00, 8'h00, 3'h4);
        run_op(`RCD_OP_XORWF, 8'hAA, 8'hAA, 8'h00, 3'h4);
        run_op(`RCD_OP_RLF, 8'h81, 8'h00, 8'h02, 3'h1);
        run_op(`RCD_OP_RRF, 8'h01, 8'h00, 8'h00, 3'h1);
        run_op(`RCD_OP_COMF, 8'h00, 8'h00, 8'hFF, 3'h0);
        run_op(`RCD_OP_MOVF, 8'h00, 8'h33, 8'h00, 3'h4);
        run_op(`RCD_OP_COMW, 8'h00, 8'hFF, 8'h00, 3'h4);
        run_op(`RCD_OP_ANDLW, 8'h00, 8'h0F, 8'h05, 3'h0);
        run_op(`RCD_OP_IORLW, 8'h00, 8'hA0, 8'hA5, 3'h0);
    endtask

    // Indirect write through the pointer, then read of the program counter.
    task automatic t_indirect;
        clear_prog();
        mem.rom[0] = 12'hB07;
        mem.rom[1] = 12'hA24;
        mem.rom[2] = 12'hB5A;
        mem.rom[3] = 12'hA20;
        mem.rom[4] = 12'hB00;
        mem.rom[5] = 12'h907;
        mem.rom[6] = 12'h902;
        restart();
        // Word j has executed once the fetch address reaches j + 2.
        reach(9'h007, 0);
        `RCD_CHK("indirect data", 8'h5A, acc)
        reach(9'h008, 4);
        `RCD_CHK("counter read", 8'h07, acc)
    endtask

    // A jump and a counter write each cost two cycles and drop one fetch.
    task automatic t_flow;
        clear_prog();
        mem.rom[0] = 12'hE10;
        mem.rom[1] = 12'hB55;
        mem.rom[16] = 12'hB20;
        mem.rom[17] = 12'hA22;
        mem.rom[18] = 12'hB55;
        mem.rom[32] = 12'hB77;
        restart();
        reach(9'h001, 0);
        reach(9'h011, 8);
        reach(9'h012, 4);
        reach(9'h021, 8);
        reach(9'h022, 4);
        `RCD_CHK("jump target result", 8'h77, acc)
        `RCD_CHK("dropped fetch ran", 1'b0, seen_stray)
    endtask

    // Quarter rate output in RC mode, and silence once the strap drops.
    task automatic t_quarter;
        logic [7:0] s;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            #1;
            s[i] = qclk;
        end
        `RCD_CHK("clock out ones", 4, $countones(s))
        `RCD_CHK("clock out period", s[3:0], s[7:4])
        @(posedge clk);
        rc_sel <= 1'b0;
        repeat (10) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            #1;
            s[i] = qclk;
        end
        `RCD_CHK("clock out idle", 8'h00, s)
        @(posedge clk);
        rc_sel <= 1'b1;
    endtask

    // Roughly twenty short programs need about six hundred clocks.
    initial
    begin
        #200000;
        errors = errors + 1;
        tally_and_finish();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_arith();
        t_logic();
        t_indirect();
        t_flow();
        t_quarter();
        tally_and_finish();
    end
endmodule
`default_nettype wire
